// ---- tsh_command_handler.sv ----
`timescale 1ns/10ps
// Behaviour
// - Each null byte shifts out next pending byte
// - Double commands need repeat within 100 ms
// - Unfinished double command dropped without answer
// - Double setup entry halts sensing, takes block
// - Answer FE, then 100 data plus CRC
// - Setup bytes over 100 ms apart abort load
// - Second FE after block stored
// - Bad block CRC answers 00 instead
// - Trailing CRC of 00 skips the check
// - Block is stored regardless of CRC result
// - Sensing resumes after load; host should reset
// - Double calibrate-all starts calibration, answers FC
// - Double forced reset answers FB, then resets
// - Status byte: bit6 comms error, bit5 fault
// - Comms error holds until last-command query
// - Status bits 3..0: sync, cal fail, cal, detect
// - First-key bit7 marks two or more touches
// - First-key bit6 marks cal, cal fail, sync, comms or line fault
// - First-key bits 4..0 key number or 1F
// - All-keys detect and error give three bytes
// - Three-byte answers end with CRC over cmd
// - One-byte reports except last-command end with CRC over cmd
// - Command 0C reports line fault status
// - Bit n marks X line; Y fault gives FF
// - Last-command query returns inverted last non-null command
module tsh_command_handler #(
  parameter int unsigned TIMEOUT_CYCLES = tsh_pkg::TIMEOUT_CYCLES
) (
  // Core clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Serial link from the host
  input  wire logic                   sclk,
  input  wire logic                   ss_n,
  input  wire logic                   mosi,
  output logic                        miso,
  output logic                        miso_oe,
  // Sensing state
  input  wire tsh_pkg::tsh_sense_type sense,
  input  wire tsh_pkg::tsh_fault_type fault,
  // Setup storage
  output tsh_pkg::tsh_nvm_type        nvm,
  input  wire logic                   nvm_busy,
  // Control towards sensing and reset
  output logic                        sensing_halt,
  output logic                        cal_all_start,
  output logic                        soft_reset
);
  import tsh_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_LOAD, S_BURN, S_RESET_ACK} tsh_state_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: shift register and bit counter on the host clock
  logic [2:0] bit_cnt;
  logic [6:0] rx_sh;
  logic [7:0] rx_hold;
  logic       rx_tog;
  logic       miso_q;
  logic [7:0] tx_byte;
  wire        link_rst_n = rst_n & ~ss_n;

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= 3'h0;
      rx_sh   <= 7'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh   <= {rx_sh[5:0], mosi};
    end
  end

  // Toggle and held byte survive the select so the core never misses a byte
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_hold <= 8'h00;
      rx_tog  <= 1'b0;
    end else if (bit_cnt == 3'h7) begin
      rx_hold <= {rx_sh, mosi};
      rx_tog  <= ~rx_tog;
    end
  end

  // Answer bits change on the falling edge; the first bit is ready at select
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= tx_byte[~bit_cnt];
    end
  end

  // tx_byte only changes right after a byte arrives, so it is still between bytes
  assign miso    = (bit_cnt == 3'h0) ? tx_byte[7] : miso_q;
  assign miso_oe = ~ss_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte event crossing into the core domain
  logic rx_sync1;
  logic rx_sync2;
  logic rx_sync3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync1 <= 1'b0;
      rx_sync2 <= 1'b0;
      rx_sync3 <= 1'b0;
    end else begin
      rx_sync1 <= rx_tog;
      rx_sync2 <= rx_sync1;
      rx_sync3 <= rx_sync2;
    end
  end

  wire       rx_valid = rx_sync2 ^ rx_sync3;
  wire [7:0] rx_byte  = rx_hold;

  ////////////////////////////////////////////////////////////////////////////////
  // Core state
  tsh_state_type state;
  logic [7:0]    resp_q [0:2];
  logic [1:0]    resp_cnt;
  logic          armed;
  logic [7:0]    arm_cmd;
  logic [23:0]   timer;
  logic [6:0]    load_cnt;
  logic [7:0]    load_crc;
  logic          load_ok;
  logic          comm_err;
  logic [7:0]    last_cmd;

  ////////////////////////////////////////////////////////////////////////////////
  // Report bytes
  logic [4:0] first_key;

  always_comb begin
    first_key = FK_NO_KEY;
    for (int k = NUM_KEYS - 1; k >= 0; k--) begin
      if (sense.detect[k]) begin
        first_key = 5'(k);
      end
    end
  end

  wire        any_fault  = fault.y_fault | (|fault.x_fault);
  wire        any_cal    = |sense.calibrating;
  wire        multi      = |(sense.detect & (sense.detect - 24'h00_0001));
  wire [7:0]  line_byte  = fault.y_fault ? ALL_FAULT : fault.x_fault;

  logic [7:0] status_byte;
  always_comb begin
    status_byte                 = 8'h00;
    status_byte[ST_COMM_ERR]    = comm_err;
    status_byte[ST_LINE_FAULT]  = any_fault;
    status_byte[ST_SYNC_FAIL]   = sense.sync_fail;
    status_byte[ST_CAL_FAIL]    = sense.cal_fail;
    status_byte[ST_CALIBRATING] = any_cal;
    status_byte[ST_DETECT]      = |sense.detect;
  end

  logic [7:0] fk_byte;
  always_comb begin
    fk_byte           = {3'h0, first_key};
    fk_byte[FK_MULTI] = multi;
    fk_byte[FK_ERROR] = any_cal | sense.cal_fail | sense.sync_fail
                        | comm_err | any_fault;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode and answer assembly
  wire is_double = (rx_byte == CMD_SETUP) | (rx_byte == CMD_CAL_ALL) | (rx_byte == CMD_RESET);
  wire dbl_hit   = is_double & armed & (arm_cmd == rx_byte);
  wire timed_out = (timer == 24'h00_0000);

  logic [7:0]  one_data;
  logic [23:0] three_data;
  logic [7:0]  resp [0:3];
  logic [2:0]  resp_len;
  logic        unknown;

  always_comb begin
    one_data   = 8'h00;
    three_data = 24'h00_0000;
    resp_len   = 3'h0;
    unknown    = 1'b0;
    unique case (rx_byte)
      CMD_STATUS:     one_data = status_byte;
      CMD_FIRST_KEY:  one_data = fk_byte;
      CMD_LINE_FAULT: one_data = line_byte;
      CMD_ALL_KEYS:   three_data = sense.detect;
      CMD_ERR_FLAGS:  three_data = sense.error;
      default:        one_data = 8'h00;
    endcase
    resp[0] = one_data;
    resp[1] = tsh_crc8(tsh_crc8(CRC_INIT, rx_byte), one_data);
    resp[2] = 8'h00;
    resp[3] = 8'h00;
    unique case (rx_byte)
      CMD_NULL, CMD_SETUP, CMD_CAL_ALL, CMD_RESET: resp_len = 3'h0;
      CMD_STATUS, CMD_FIRST_KEY, CMD_LINE_FAULT:   resp_len = 3'h2;
      CMD_ALL_KEYS, CMD_ERR_FLAGS: begin
        resp_len = 3'h4;
        resp[0]  = three_data[7:0];
        resp[1]  = three_data[15:8];
        resp[2]  = three_data[23:16];
        resp[3]  = tsh_crc8(tsh_crc8(tsh_crc8(tsh_crc8(CRC_INIT, rx_byte),
                   three_data[7:0]), three_data[15:8]), three_data[23:16]);
      end
      CMD_LAST_CMD: begin
        resp_len = 3'h1;
        resp[0]  = ~last_cmd;
      end
      default:      unknown = 1'b1;
    endcase
  end

  wire [7:0] next_crc  = tsh_crc8(load_crc, rx_byte);
  wire       load_last = (load_cnt == SETUP_LEN);
  wire       crc_pass  = (rx_byte == CRC_SKIP) | (rx_byte == load_crc);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= S_IDLE;
      tx_byte       <= IDLE_BYTE;
      resp_q[0]     <= 8'h00;
      resp_q[1]     <= 8'h00;
      resp_q[2]     <= 8'h00;
      resp_cnt      <= 2'h0;
      armed         <= 1'b0;
      arm_cmd       <= 8'h00;
      timer         <= 24'h00_0000;
      load_cnt      <= 7'h00;
      load_crc      <= CRC_INIT;
      load_ok       <= 1'b0;
      comm_err      <= 1'b0;
      last_cmd      <= 8'h00;
      nvm           <= '0;
      sensing_halt  <= 1'b0;
      cal_all_start <= 1'b0;
      soft_reset    <= 1'b0;
    end else begin
      nvm.wr        <= 1'b0;
      cal_all_start <= 1'b0;
      soft_reset    <= 1'b0;
      if (!timed_out) begin
        timer <= timer - 24'h00_0001;
      end
      unique case (state)
        S_IDLE: begin
          if (timed_out) begin
            armed <= 1'b0;
          end
          if (rx_valid) begin
            armed <= 1'b0;
            if (rx_byte == CMD_NULL) begin
              tx_byte   <= (resp_cnt != 2'h0) ? resp_q[0] : IDLE_BYTE;
              resp_q[0] <= resp_q[1];
              resp_q[1] <= resp_q[2];
              resp_cnt  <= (resp_cnt != 2'h0) ? resp_cnt - 2'h1 : 2'h0;
            end else begin
              last_cmd  <= rx_byte;
              tx_byte   <= (resp_len != 3'h0) ? resp[0] : IDLE_BYTE;
              resp_q[0] <= resp[1];
              resp_q[1] <= resp[2];
              resp_q[2] <= resp[3];
              resp_cnt  <= (resp_len != 3'h0) ? 2'(resp_len - 3'h1) : 2'h0;
            end
            if (unknown) begin
              comm_err <= 1'b1;
            end else if (rx_byte == CMD_LAST_CMD) begin
              comm_err <= 1'b0;
            end
            if (is_double && !dbl_hit) begin
              armed   <= 1'b1;
              arm_cmd <= rx_byte;
              timer   <= TIMEOUT_CYCLES[23:0];
            end
            if (dbl_hit) begin
              resp_cnt <= 2'h0;
              unique case (rx_byte)
                CMD_SETUP: begin
                  tx_byte      <= ACK_SETUP;
                  sensing_halt <= 1'b1;
                  load_cnt     <= 7'h00;
                  load_crc     <= CRC_INIT;
                  timer        <= TIMEOUT_CYCLES[23:0];
                  state        <= S_LOAD;
                end
                CMD_CAL_ALL: begin
                  tx_byte       <= ACK_CAL;
                  cal_all_start <= 1'b1;
                end
                default: begin
                  tx_byte <= ACK_RESET;
                  state   <= S_RESET_ACK;
                end
              endcase
            end
          end
        end
        S_LOAD: begin
          if (rx_valid) begin
            timer <= TIMEOUT_CYCLES[23:0];
            if (load_last) begin
              load_ok <= crc_pass;
              state   <= S_BURN;
            end else begin
              nvm.wr   <= 1'b1;
              nvm.addr <= load_cnt;
              nvm.data <= rx_byte;
              load_crc <= next_crc;
              load_cnt <= load_cnt + 7'h01;
            end
          end else if (timed_out) begin
            sensing_halt <= 1'b0;
            state        <= S_IDLE;
          end
        end
        S_BURN: begin
          // Busy is sampled a byte time after the last write, so it is settled
          if (!nvm_busy) begin
            tx_byte      <= load_ok ? ACK_SETUP : NACK_SETUP;
            sensing_halt <= 1'b0;
            state        <= S_IDLE;
          end
        end
        S_RESET_ACK: begin
          // The reset waits until the host has clocked the acknowledge out
          if (rx_valid) begin
            soft_reset <= 1'b1;
            tx_byte    <= IDLE_BYTE;
            state      <= S_IDLE;
          end
        end
      endcase
    end
  end

endmodule : tsh_command_handler

// ---- tsh_pkg.sv ----
package tsh_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Command and answer codes
  localparam logic [7:0] CMD_NULL       = 8'h00;
  localparam logic [7:0] CMD_SETUP      = 8'h01;
  localparam logic [7:0] CMD_CAL_ALL    = 8'h03;
  localparam logic [7:0] CMD_RESET      = 8'h04;
  localparam logic [7:0] CMD_STATUS     = 8'h05;
  localparam logic [7:0] CMD_FIRST_KEY  = 8'h06;
  localparam logic [7:0] CMD_ALL_KEYS   = 8'h07;
  localparam logic [7:0] CMD_ERR_FLAGS  = 8'h0B;
  localparam logic [7:0] CMD_LINE_FAULT = 8'h0C;
  localparam logic [7:0] CMD_LAST_CMD   = 8'h0F;
  localparam logic [7:0] ACK_SETUP      = 8'hFE;
  localparam logic [7:0] NACK_SETUP     = 8'h00;
  localparam logic [7:0] ACK_CAL        = 8'hFC;
  localparam logic [7:0] ACK_RESET      = 8'hFB;
  localparam logic [7:0] IDLE_BYTE      = 8'h00;
  localparam logic [7:0] ALL_FAULT      = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and sizes
  localparam int         ST_COMM_ERR    = 6;
  localparam int         ST_LINE_FAULT  = 5;
  localparam int         ST_SYNC_FAIL   = 3;
  localparam int         ST_CAL_FAIL    = 2;
  localparam int         ST_CALIBRATING = 1;
  localparam int         ST_DETECT      = 0;
  localparam int         FK_MULTI       = 7;
  localparam int         FK_ERROR       = 6;
  localparam logic [4:0] FK_NO_KEY      = 5'h1F;
  localparam int         NUM_KEYS       = 24;
  localparam logic [6:0] SETUP_LEN      = 7'h64;
  localparam logic [7:0] CRC_SKIP       = 8'h00;
  localparam logic [7:0] CRC_POLY       = 8'h31;
  localparam logic [7:0] CRC_INIT       = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned TIMEOUT_MS     = 100;
  localparam int unsigned CLK_KHZ        = 125000;
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [23:0] detect;
    logic [23:0] calibrating;
    logic [23:0] error;
    logic        cal_fail;
    logic        sync_fail;
  } tsh_sense_type;

  typedef struct packed {
    logic [7:0] x_fault;
    logic       y_fault;
  } tsh_fault_type;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } tsh_nvm_type;

  function automatic logic [7:0] tsh_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : tsh_crc8

endpackage : tsh_pkg

// ---- tsh_command_handler_props.sv ----
`timescale 1ns/10ps
module tsh_command_handler_props #(
  parameter int unsigned TIMEOUT_CYCLES = tsh_pkg::TIMEOUT_CYCLES
) (
  // Core
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Link
  input wire logic                   sclk,
  input wire logic                   ss_n,
  input wire logic                   mosi,
  input wire logic                   miso,
  input wire logic                   miso_oe,
  // Sensing and storage
  input wire tsh_pkg::tsh_sense_type sense,
  input wire tsh_pkg::tsh_fault_type fault,
  input wire tsh_pkg::tsh_nvm_type   nvm,
  input wire logic                   nvm_busy,
  // Control
  input wire logic                   sensing_halt,
  input wire logic                   cal_all_start,
  input wire logic                   soft_reset
);
  import tsh_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Cycles of a load with no stored byte; bounds a stuck load
  logic [23:0] quiet;
  logic [23:0] next_quiet;
  logic [6:0]  last_addr;
  assign next_quiet = (nvm.wr || !sensing_halt) ? 24'h00_0000 : quiet + 24'h00_0001;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= 24'h00_0000;
      last_addr <= 7'h00;
    end else begin
      quiet <= next_quiet;
      last_addr <= nvm.wr ? nvm.addr : last_addr;
    end
  end
  ////////////////////////////////////////////////////////////
  oe_select_a: assert property (miso_oe == !ss_n)
    else $error("pin enable does not follow select");
  wr_pulse_a: assert property (nvm.wr |=> !nvm.wr)
    else $error("storage write longer than one cycle");
  wr_in_load_a: assert property (nvm.wr |-> sensing_halt && nvm.addr < SETUP_LEN)
    else $error("storage write outside a setup load");
  addr_step_a: assert property (nvm.wr && nvm.addr != 7'h00 |-> nvm.addr == 7'(last_addr + 7'h01))
    else $error("storage address skipped");
  load_abort_a: assert property (quiet <= 24'(TIMEOUT_CYCLES + 16))
    else $error("stalled setup load not abandoned");
  cal_start_a: assert property (cal_all_start |-> !sensing_halt ##1 !cal_all_start)
    else $error("calibration start malformed");
  reset_pulse_a: assert property (soft_reset |=> !soft_reset [*3])
    else $error("reset request repeated");
  reset_alone_a: assert property (soft_reset |-> !sensing_halt && !cal_all_start)
    else $error("reset request during other action");
  full_load_c: cover property (nvm.wr && nvm.addr == 7'h63);
endmodule : tsh_command_handler_props

bind tsh_command_handler tsh_command_handler_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
  .clk(clk), .rst_n(rst_n), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso),
  .miso_oe(miso_oe), .sense(sense), .fault(fault), .nvm(nvm), .nvm_busy(nvm_busy),
  .sensing_halt(sensing_halt), .cal_all_start(cal_all_start), .soft_reset(soft_reset)
);

// ---- tsh_host_model.sv ----
`timescale 1ns/10ps
module tsh_host_model (
  // Link pins
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b1;
  end
  // One byte per frame, 48 ns clock that stands still between frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    ss_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #24 rx[i] = miso;
      sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    #24 ss_n = 1'b1;
    // Released line shows no stale bit
    mosi = ~tx[0];
    #200;
  endtask : xfer
endmodule : tsh_host_model

// ---- tsh_command_handler_tb_top.sv ----
`timescale 1ns/10ps
module tsh_command_handler_tb_top;
  import tsh_pkg::*;
  logic          clk;
  logic          rst_n;
  logic          sclk, ss_n, mosi, miso, miso_oe;
  logic          sensing_halt, cal_all_start, soft_reset;
  logic          nvm_busy = 1'b0;
  tsh_sense_type sense = '0;
  tsh_fault_type fault = '0;
  tsh_nvm_type   nvm;
  int            failures, samples_checked, cal_seen, rst_seen, wr_seen;
  logic [7:0]    ans [0:3];
  logic [7:0]    blk [0:99];
  ////////////////////////////////////////////////////////////
  tsh_command_handler #(.TIMEOUT_CYCLES(200)) u_tsh_command_handler (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .sense(sense), .fault(fault), .nvm(nvm), .nvm_busy(nvm_busy),
    .sensing_halt(sensing_halt), .cal_all_start(cal_all_start), .soft_reset(soft_reset));
  tsh_host_model u_tsh_host_model (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Storage busy one cycle per write; watch pulses and stored data
  always @(posedge clk) begin
    nvm_busy <= nvm.wr;
    if (cal_all_start === 1'b1) cal_seen++;
    if (soft_reset === 1'b1) rst_seen++;
    if (nvm.wr === 1'b1) begin
      wr_seen++;
      chk(nvm.data, blk[nvm.addr]);
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction : crc
  function automatic logic [7:0] stat(input logic ce);
    return {1'b0, ce, |fault.x_fault | fault.y_fault, 1'b0, sense.sync_fail, sense.cal_fail,
            |sense.calibrating, |sense.detect};
  endfunction : stat
  function automatic logic [7:0] fk(input logic ce);
    logic [4:0] k;
    k = FK_NO_KEY;
    for (int i = 23; i >= 0; i--) if (sense.detect[i]) k = 5'(i);
    return {$countones(sense.detect) > 1, |sense.calibrating | sense.cal_fail | sense.sync_fail
            | ce | |fault.x_fault | fault.y_fault, 1'b0, k};
  endfunction : fk
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c, input int n);
    logic [7:0] r;
    u_tsh_host_model.xfer(c, r);
    for (int i = 0; i < n; i++) u_tsh_host_model.xfer(CMD_NULL, ans[i]);
  endtask : cmd
  task automatic rep(input logic [7:0] c, input logic [7:0] d);
    cmd(c, 2);
    chk(ans[0], d);
    chk(ans[1], crc(crc(CRC_INIT, c), d));
  endtask : rep
  task automatic all(input logic [7:0] c, input logic [23:0] k);
    logic [7:0] e;
    cmd(c, 4);
    e = crc(CRC_INIT, c);
    for (int i = 0; i < 3; i++) begin
      chk(ans[i], k[8*i +: 8]);
      e = crc(e, k[8*i +: 8]);
    end
    chk(ans[3], e);
  endtask : all
  // Mode 0 sends the right trailer, 1 a zero trailer, 2 a wrong one
  task automatic load(input int mode, input logic [7:0] e);
    logic [7:0] c, r;
    c = CRC_INIT;
    cmd(CMD_SETUP, 0);
    u_tsh_host_model.xfer(CMD_SETUP, r);
    wr_seen = 0;
    for (int i = 0; i < 100; i++) begin
      u_tsh_host_model.xfer(blk[i], r);
      c = crc(c, blk[i]);
      if (i == 0) chk(r, ACK_SETUP);
      if (i == 50) chk({7'h00, sensing_halt}, 8'h01);
    end
    u_tsh_host_model.xfer(mode == 0 ? c : mode == 1 ? CRC_SKIP : ~c, r);
    u_tsh_host_model.xfer(CMD_NULL, r);
    chk(r, e);
    chk(8'(wr_seen), 8'h64);
    chk({7'h00, sensing_halt}, 8'h00);
  endtask : load
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////
  initial begin
    #600_000;
    failures++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    for (int i = 0; i < 100; i++) blk[i] = 8'(i * 7 + 3);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    sense <= {24'h00_0208, 24'h00_0000, 24'h80_0001, 1'b0, 1'b1};
    fault <= {8'h25, 1'b0};
    @(posedge clk);
    rep(CMD_STATUS, stat(1'b0));
    rep(CMD_FIRST_KEY, fk(1'b0));
    rep(CMD_LINE_FAULT, 8'h25);
    all(CMD_ALL_KEYS, sense.detect);
    all(CMD_ERR_FLAGS, sense.error);
    sense <= '0;
    fault <= {8'h00, 1'b1};
    @(posedge clk);
    rep(CMD_LINE_FAULT, ALL_FAULT);
    rep(CMD_FIRST_KEY, fk(1'b0));
    fault <= '0;
    cmd(8'h0D, 1);
    chk(ans[0], IDLE_BYTE);
    rep(CMD_STATUS, stat(1'b1));
    cmd(8'hC3, 0);
    cmd(CMD_LAST_CMD, 1);
    chk(ans[0], 8'h3C);
    rep(CMD_STATUS, stat(1'b0));
    cmd(CMD_LAST_CMD, 0);
    cmd(CMD_LAST_CMD, 1);
    chk(ans[0], 8'hF0);
    cmd(CMD_CAL_ALL, 0);
    cmd(CMD_CAL_ALL, 1);
    chk(ans[0], ACK_CAL);
    chk(8'(cal_seen), 8'h01);
    cmd(CMD_CAL_ALL, 0);
    cmd(CMD_STATUS, 0);
    cmd(CMD_CAL_ALL, 1);
    chk(ans[0], IDLE_BYTE);
    // First half left to expire, so the repeat must start a fresh window
    cmd(CMD_CAL_ALL, 0);
    repeat (250) @(posedge clk);
    cmd(CMD_CAL_ALL, 1);
    chk(ans[0], IDLE_BYTE);
    repeat (250) @(posedge clk);
    chk(8'(cal_seen), 8'h01);
    cmd(CMD_RESET, 0);
    cmd(CMD_RESET, 1);
    chk(ans[0], ACK_RESET);
    chk(8'(rst_seen), 8'h01);
    load(0, ACK_SETUP);
    load(1, ACK_SETUP);
    load(2, NACK_SETUP);
    cmd(CMD_SETUP, 0);
    cmd(CMD_SETUP, 0);
    cmd(blk[0], 0);
    repeat (250) @(posedge clk);
    chk({7'h00, sensing_halt}, 8'h00);
    rep(CMD_STATUS, stat(1'b0));
    report_and_stop();
  end
endmodule : tsh_command_handler_tb_top
